// File: hw/lin_ext.sv
// lin serial extensions: auto-baud, overflow, wake on break, break transmit
// assumes aclk is the oscillator and software reaches the registers over axi4-lite
`include "lin_ext_defines.svh"

module lin_ext
    import lin_ext_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        rx_pin,
    output logic             tx_pin,
    output logic             rx_int_flag,
    output logic             tx_int_flag
);

    state_t      st;
    state_t      next_st;
    logic        rise;
    logic        fall;
    logic        base_tick;
    logic        cal_tick;
    logic        bit_end;
    logic [5:0]  base_tc;
    logic [15:0] tx_div;
    logic [31:0] rd_word;
    logic        rd_hit;
    logic [7:0]  wbyte;

    // ****************************************
    // register read mux
    // ****************************************
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            `OFS_BAUD_CTRL: begin
                rd_word[`BC_CALIB] = st.autobaud_enable;
                rd_word[`BC_WAKE]  = st.wake_on_break_enable;
                rd_word[`BC_WIDE]  = st.wide_divider_sel;
                rd_word[`BC_IDLE]  = (st.cal == AB_IDLE) || (st.cal == AB_START);
                rd_word[`BC_OVF]   = st.autobaud_overflow;
            end
            `OFS_TX_CTRL: begin
                rd_word[`TC_EMPTY] = st.tx_shift_empty;
                rd_word[`TC_FAST]  = st.high_speed_sel;
                rd_word[`TC_BREAK] = st.send_break;
                rd_word[`TC_SYNC]  = st.sync_mode;
                rd_word[`TC_TXON]  = st.tx_enable;
            end
            `OFS_DIV_LOW:  rd_word[7:0] = st.baud_div[7:0];
            `OFS_DIV_HIGH: rd_word[7:0] = st.baud_div[15:8];
            // received characters are handled outside; reads return zero
            `OFS_RX_DATA:  rd_word = 32'h0000_0000;
            `OFS_TX_DATA:  rd_word = 32'h0000_0000;
            `OFS_FLAGS: begin
                rd_word[`FL_RX] = st.rx_int_flag;
                rd_word[`FL_TX] = st.tx_int_flag;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // ****************************************
    // timing helpers
    // ****************************************
    always_comb begin
        rise = st.rx_sync && !st.rx_prev;
        fall = !st.rx_sync && st.rx_prev;
        case ({st.wide_divider_sel, st.high_speed_sel})
            2'b00:   base_tc = `BASE_TC_SLOW;
            2'b11:   base_tc = `BASE_TC_FAST;
            default: base_tc = `BASE_TC_MID;
        endcase
        base_tick = (st.base_cnt >= base_tc);
        cal_tick  = base_tick && (st.cal_pre == `CAL_PRESCALE_TC);
        tx_div    = st.wide_divider_sel ? st.baud_div : {8'h00, st.baud_div[7:0]};
        bit_end   = base_tick && (st.tx_baud_cnt >= tx_div);
        wbyte     = st.w_data[7:0];
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_st = st;
        // only the second and third stages feed edge detection
        next_st.rx_meta  = rx_pin;
        next_st.rx_sync  = st.rx_meta;
        next_st.rx_prev  = st.rx_sync;
        next_st.base_cnt = base_tick ? 6'h00 : st.base_cnt + 6'h01;
        if (base_tick) begin
            next_st.cal_pre = st.cal_pre + 3'h1;
        end

        // bus: address and data may arrive in either order
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_got  = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_got  = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.aw_got && st.w_got && !st.bvalid) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = `RESP_OKAY;
            case (st.aw_addr)
                `OFS_BAUD_CTRL: if (st.w_strb[0]) begin
                    next_st.autobaud_enable      = wbyte[`BC_CALIB];
                    next_st.wake_on_break_enable = wbyte[`BC_WAKE];
                    next_st.wide_divider_sel     = wbyte[`BC_WIDE];
                    // overflow clears only with calibration stopped
                    if (!wbyte[`BC_OVF] && !st.autobaud_enable) begin
                        next_st.autobaud_overflow = 1'b0;
                    end
                end
                `OFS_TX_CTRL: if (st.w_strb[0]) begin
                    next_st.high_speed_sel = wbyte[`TC_FAST];
                    next_st.send_break     = wbyte[`TC_BREAK];
                    next_st.sync_mode      = wbyte[`TC_SYNC];
                    next_st.tx_enable      = wbyte[`TC_TXON];
                end
                `OFS_DIV_LOW:  if (st.w_strb[0]) next_st.baud_div[7:0]  = wbyte;
                `OFS_DIV_HIGH: if (st.w_strb[0]) next_st.baud_div[15:8] = wbyte;
                `OFS_TX_DATA: begin
                    // a write into a full buffer is dropped
                    if (st.w_strb[0] && st.tx_enable && !st.tx_buf_valid) begin
                        next_st.tx_buf_valid = 1'b1;
                        next_st.tx_buf       = wbyte;
                        next_st.tx_buf_break = st.send_break && !st.break_active;
                    end
                end
                `OFS_RX_DATA, `OFS_FLAGS: begin
                end
                default: next_st.bresp = `RESP_SLVERR;
            endcase
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = rd_word;
            next_st.rresp  = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            if (s_axi_araddr == `OFS_RX_DATA) begin
                next_st.rx_int_flag = 1'b0;
            end
        end

        // auto-baud: hardware sets below override the bus clears above
        if (!st.autobaud_enable || st.sync_mode) begin
            next_st.cal = AB_IDLE;
        end else begin
            case (st.cal)
                AB_IDLE: begin
                    // start sequence, wait out the break first
                    if (!st.wake_on_break_enable) begin
                        next_st.cal = AB_START;
                    end
                end
                AB_START: begin
                    if (fall) begin
                        next_st.cal = AB_RISE1;
                    end
                end
                AB_RISE1: begin
                    // first rise after start, count from one
                    if (rise) begin
                        next_st.cal       = AB_COUNT;
                        next_st.baud_div  = `CAL_START_CNT;
                        next_st.cal_edges = 3'h1;
                        next_st.cal_pre   = 3'h0;
                        next_st.base_cnt  = 6'h00;
                    end
                end
                AB_COUNT: begin
                    // full 16-bit count regardless of width select
                    if (cal_tick) begin
                        next_st.baud_div = st.baud_div + 16'h0001;
                        if (st.baud_div == `DIV_MAX) begin
                            next_st.autobaud_overflow = 1'b1;
                        end
                    end
                    if (rise) begin
                        next_st.cal_edges = st.cal_edges + 3'h1;
                        // fifth rise ends it; also after overflow
                        if (st.cal_edges == `CAL_LAST_EDGE) begin
                            next_st.cal             = AB_IDLE;
                            next_st.autobaud_enable = 1'b0;
                            next_st.rx_int_flag     = 1'b1;
                        end
                    end
                end
                default: next_st.cal = AB_IDLE;
            endcase
        end

        if (st.wake_on_break_enable && !st.sync_mode) begin
            // wake flag, any start bit counts as the event
            if (fall) begin
                next_st.rx_int_flag = 1'b1;
            end
            if (rise) begin
                next_st.wake_on_break_enable = 1'b0;
            end
        end

        // ****************************************
        // transmitter
        // ****************************************
        next_st.tx_baud_cnt = bit_end ? 16'h0000
                            : (base_tick ? st.tx_baud_cnt + 16'h0001 : st.tx_baud_cnt);
        case (st.tx)
            TX_IDLE: begin
                next_st.tx_baud_cnt = 16'h0000;
                // start on a base tick: a free-running tick phase would cut the first bit short
                if (st.tx_buf_valid && st.tx_enable && base_tick) begin
                    next_st.tx           = TX_SHIFT;
                    next_st.tx_buf_valid = 1'b0;
                    next_st.break_active = st.tx_buf_break;
                    if (st.tx_buf_break) begin
                        next_st.tx_shreg = `TX_BREAK_FRAME;
                        next_st.tx_bits  = `BREAK_BITS;
                    end else begin
                        next_st.tx_shreg = {`TX_IDLE_FILL, st.tx_buf, 1'b0};
                        next_st.tx_bits  = `NORMAL_BITS;
                    end
                end
            end
            TX_SHIFT: begin
                if (bit_end) begin
                    next_st.tx_shreg = {1'b1, st.tx_shreg[13:1]};
                    next_st.tx_bits  = st.tx_bits - 4'h1;
                    if (st.tx_bits == 4'h1) begin
                        next_st.tx           = TX_IDLE;
                        next_st.break_active = 1'b0;
                        if (st.break_active) begin
                            next_st.send_break = 1'b0;
                        end
                    end
                end
            end
            default: next_st.tx = TX_IDLE;
        endcase
        next_st.tx_pin = (next_st.tx == TX_SHIFT) ? next_st.tx_shreg[0] : 1'b1;
        next_st.tx_shift_empty = (next_st.tx == TX_IDLE);
        next_st.tx_int_flag    = !next_st.tx_buf_valid;

        next_st.awready = !next_st.aw_got && !next_st.bvalid;
        next_st.wready  = !next_st.w_got && !next_st.bvalid;
        next_st.arready = !next_st.rvalid;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st                <= '0;
            st.cal            <= AB_IDLE;
            st.tx             <= TX_IDLE;
            st.rx_meta        <= 1'b1;
            st.rx_sync        <= 1'b1;
            st.rx_prev        <= 1'b1;
            st.tx_pin         <= 1'b1;
            st.tx_int_flag    <= 1'b1;
            st.tx_shift_empty <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;
    assign tx_pin        = st.tx_pin;
    assign rx_int_flag   = st.rx_int_flag;
    assign tx_int_flag   = st.tx_int_flag;

endmodule

// File: hw/lin_ext_defines.svh
// register offsets, bit positions, counts and constants of the lin serial extensions
// assumes a 32-bit axi4-lite slave with byte addresses of 8 bits
`ifndef LIN_EXT_DEFINES_SVH
`define LIN_EXT_DEFINES_SVH

// ****************************************
// register map
// ****************************************
`define OFS_BAUD_CTRL    8'h00
`define OFS_TX_CTRL      8'h04
`define OFS_DIV_LOW      8'h08
`define OFS_DIV_HIGH     8'h0C
`define OFS_RX_DATA      8'h10
`define OFS_TX_DATA      8'h14
`define OFS_FLAGS        8'h18

// ****************************************
// field positions
// ****************************************
`define BC_CALIB         0
`define BC_WAKE          1
`define BC_WIDE          3
`define BC_IDLE          6
`define BC_OVF           7
`define TC_EMPTY         1
`define TC_FAST          2
`define TC_BREAK         3
`define TC_SYNC          4
`define TC_TXON          5
`define FL_RX            0
`define FL_TX            1

// ****************************************
// counts and constants
// ****************************************
`define BASE_TC_SLOW     6'h3F
`define BASE_TC_MID      6'h0F
`define BASE_TC_FAST     6'h03
`define CAL_PRESCALE_TC  3'h7
`define CAL_LAST_EDGE    3'h4
`define CAL_START_CNT    16'h0001
`define DIV_MAX          16'hFFFF
`define NORMAL_BITS      4'hA
`define BREAK_BITS       4'hE
`define TX_IDLE_FILL     5'h1F
`define TX_BREAK_FRAME   14'h2000
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// File: hw/lin_ext_pkg.sv
// types of the lin serial extensions: state machine codes and the module state
// assumes lin_ext_defines.svh for all numeric constants
package lin_ext_pkg;

    typedef enum logic [3:0] {
        AB_IDLE  = 4'b0001,
        AB_START = 4'b0010,
        AB_RISE1 = 4'b0100,
        AB_COUNT = 4'b1000
    } cal_state_t;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b01,
        TX_SHIFT = 2'b10
    } tx_state_t;

    typedef struct packed {
        logic        awready, wready, bvalid, arready, rvalid;
        logic [1:0]  bresp, rresp;
        logic [31:0] rdata;
        logic        aw_got, w_got;
        logic [7:0]  aw_addr;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        rx_meta, rx_sync, rx_prev;
        logic        autobaud_enable, autobaud_overflow, wake_on_break_enable;
        logic        wide_divider_sel, high_speed_sel, send_break, tx_enable, sync_mode;
        logic        rx_int_flag;
        logic [15:0] baud_div;
        cal_state_t  cal;
        logic [2:0]  cal_edges;
        logic [5:0]  base_cnt;
        logic [2:0]  cal_pre;
        tx_state_t   tx;
        logic        tx_buf_valid, tx_buf_break, break_active;
        logic [7:0]  tx_buf;
        logic [13:0] tx_shreg;
        logic [3:0]  tx_bits;
        logic [15:0] tx_baud_cnt;
        logic        tx_pin, tx_int_flag, tx_shift_empty;
    } state_t;

endpackage

// File: verification/lin_ext_assertions.sv
// port assertions of the lin serial extensions
// assumes binding to lin_ext; one clock, synchronous active-low reset
`include "lin_ext_defines.svh"
module lin_ext_assertions (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        rx_pin,
    input wire logic        rx_int_flag,
    input wire logic        tx_int_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] since_edge;
    logic [7:0] since_wr;
    logic       rx_q;
    logic       ar_rx;
    assign ar_rx = s_axi_arvalid && s_axi_arready && (s_axi_araddr == `OFS_RX_DATA);
    // saturating ages: flag moves must sit close to their cause
    always_ff @(posedge aclk) begin
        rx_q <= rx_pin;
        if (!aresetn || rx_pin != rx_q)
            since_edge <= (aresetn) ? 8'h00 : 8'hFF;
        else if (since_edge != 8'hFF)
            since_edge <= since_edge + 8'h01;
        if (aresetn && s_axi_wvalid && s_axi_wready)
            since_wr <= 8'h00;
        else if (since_wr != 8'hFF)
            since_wr <= since_wr + 8'h01;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    b_hold_a:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    r_hold_a:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    w_block_a:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    ar_block_a:
        assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    r_answer_a:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    b_answer_a:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                         |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    rdata_byte_a:
        assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000
                         && (s_axi_rresp != `RESP_SLVERR || s_axi_rdata == 32'h0000_0000))
        else $error("read data outside byte lane");
    rx_rise_a:
        assert property ($rose(rx_int_flag) |-> since_edge <= 8'h04)
        else $error("receive flag set without rx edge");
    rx_clear_a:
        assert property ($fell(rx_int_flag) |-> $past(ar_rx) || $past(ar_rx, 2) || $past(ar_rx, 3))
        else $error("receive flag cleared without data read");
    tx_full_a:
        assert property ($fell(tx_int_flag) |-> since_wr <= 8'h04)
        else $error("transmit flag fell without a write");
    cover property ($rose(rx_int_flag));
    cover property ($fell(tx_int_flag));
    cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
endmodule

bind lin_ext lin_ext_assertions u_lin_ext_assertions (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .rx_pin, .rx_int_flag, .tx_int_flag
);

// File: verification/lin_ext_tb.sv
// self-checking bench of the lin serial extensions over axi4-lite
// assumes lin_node_model on rx_pin and the bound port checker
`include "lin_ext_defines.svh"
module lin_ext_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'h0;
    logic        aresetn = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, rd;
    logic        rx_pin, tx_pin, rx_int_flag, tx_int_flag;
    int          miscompares = 0, check_count = 0, cycles = 0, run = 0;
    int          lows[$];
    lin_ext u_lin_ext (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_pin, .tx_pin, .rx_int_flag,
        .tx_int_flag);
    lin_node_model u_lin_node_model (.aclk, .rx_pin);
    always #2.5 aclk = ~aclk;
    // low run lengths of tx_pin give the frame shape
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (tx_pin === 1'h0)
            run <= run + 1;
        else if (run != 0) begin
            lows.push_back(run);
            run <= 0;
        end
        if (cycles == 70000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check_word(input logic [31:0] got, input logic [31:0] want);
        check_count++;
        if (got !== want) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic check_resp(input logic [1:0] got, input logic [1:0] want);
        check_word({30'h0, got}, {30'h0, want});
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        aw = 1'h1;
        w = 1'h1;
        b = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!b) begin
            @(posedge aclk);
            if (aw && s_axi_awready === 1'h1) begin
                aw = 1'h0;
                s_axi_awvalid <= 1'h0;
            end
            if (w && s_axi_wready === 1'h1) begin
                w = 1'h0;
                s_axi_wvalid <= 1'h0;
            end
            if (s_axi_bvalid === 1'h1) begin
                b = 1'h1;
                rs = s_axi_bresp;
                s_axi_bready <= 1'h0;
            end
        end
    endtask
    task automatic axi_read(input logic [7:0] a);
        logic ar, r;
        ar = 1'h1;
        r = 1'h0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        while (!r) begin
            @(posedge aclk);
            if (ar && s_axi_arready === 1'h1) begin
                ar = 1'h0;
                s_axi_arvalid <= 1'h0;
            end
            if (s_axi_rvalid === 1'h1) begin
                r = 1'h1;
                rd = s_axi_rdata;
                rs = s_axi_rresp;
                s_axi_rready <= 1'h0;
            end
        end
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [31:0] want);
        axi_read(a);
        check_word(rd, want);
    endtask
    // one 55h sync: count = 8 bit times over the counter period, plus one
    task automatic calibrate(input logic wide, input logic fast, input logic wake,
                             input int bit_cyc, input logic [15:0] want);
        axi_write(`OFS_TX_CTRL, {29'h0, fast, 2'h0});
        axi_write(`OFS_BAUD_CTRL, {28'h0, wide, 1'h0, wake, 1'h1});
        if (wake) begin
            u_lin_node_model.send_wake(bit_cyc);
            check_word({31'h0, rx_int_flag}, 32'h0000_0001);
            expect_reg(`OFS_RX_DATA, 32'h0000_0000);
            expect_reg(`OFS_BAUD_CTRL, {25'h0, 1'h1, 2'h0, wide, 3'h1});
        end
        fork
            u_lin_node_model.send_byte(bit_cyc, 8'h55);
            begin
                repeat (3 * bit_cyc) @(posedge aclk);
                expect_reg(`OFS_BAUD_CTRL, {28'h0, wide, 3'h1});
            end
        join
        check_word({31'h0, rx_int_flag}, 32'h0000_0001);
        expect_reg(`OFS_BAUD_CTRL, {25'h0, 1'h1, 2'h0, wide, 3'h0});
        expect_reg(`OFS_DIV_LOW, {24'h0, want[7:0]});
        expect_reg(`OFS_DIV_HIGH, {24'h0, want[15:8]});
        expect_reg(`OFS_RX_DATA, 32'h0000_0000);
        repeat (2) @(posedge aclk);
        check_word({31'h0, rx_int_flag}, 32'h0000_0000);
        $display("calibration test done");
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        expect_reg(`OFS_BAUD_CTRL, 32'h0000_0040);
        expect_reg(`OFS_TX_CTRL, 32'h0000_0002);
        expect_reg(`OFS_FLAGS, 32'h0000_0002);
        axi_write(`OFS_BAUD_CTRL, 32'h0000_0080);
        expect_reg(`OFS_BAUD_CTRL, 32'h0000_0040);
        axi_read(8'h1C);
        check_resp(rs, `RESP_SLVERR);
        axi_write(8'h1C, 32'h0000_00FF);
        check_resp(rs, `RESP_SLVERR);
        $display("register test done");
        calibrate(1'h0, 1'h0, 1'h0, 512, 16'h0009);
        calibrate(1'h1, 1'h0, 1'h0, 128, 16'h0009);
        calibrate(1'h0, 1'h1, 1'h0, 4096, 16'h0101);
        calibrate(1'h1, 1'h1, 1'h1, 64, 16'h0011);
        // synchronous mode: wake must stay inert
        axi_write(`OFS_TX_CTRL, 32'h0000_0010);
        axi_write(`OFS_BAUD_CTRL, 32'h0000_0002);
        u_lin_node_model.send_wake(8);
        check_word({31'h0, rx_int_flag}, 32'h0000_0000);
        axi_write(`OFS_BAUD_CTRL, 32'h0000_0008);
        $display("sync mode test done");
        // break then preloaded sync, bit time two base ticks of four cycles
        axi_write(`OFS_DIV_LOW, 32'h0000_0001);
        axi_write(`OFS_DIV_HIGH, 32'h0000_0000);
        axi_write(`OFS_TX_CTRL, 32'h0000_002C);
        lows.delete();
        axi_write(`OFS_TX_DATA, 32'h0000_00AA);
        // software waits for buffer room before preloading the sync byte
        while (tx_int_flag !== 1'h1)
            @(posedge aclk);
        axi_write(`OFS_TX_DATA, 32'h0000_0055);
        check_word({31'h0, tx_int_flag}, 32'h0000_0000);
        expect_reg(`OFS_TX_CTRL, 32'h0000_002C);
        while (lows.size() < 6)
            @(posedge aclk);
        repeat (12) @(posedge aclk);
        check_word(lows[0], 32'h0000_0068);
        for (int i = 1; i < 6; i++)
            check_word(lows[i], 32'h0000_0008);
        expect_reg(`OFS_TX_CTRL, 32'h0000_0026);
        check_word({31'h0, tx_int_flag}, 32'h0000_0001);
        $display("break test done");
        complete_run();
    end
endmodule

// File: verification/lin_node_model.sv
// remote serial node driving the receive line of the block
// assumes the bench calls its tasks just after a rising clock edge
module lin_node_model (
    input  wire logic aclk,
    output logic      rx_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rx_pin = 1'h1;
    task automatic hold(input logic v, input int n);
        rx_pin <= v;
        repeat (n) @(posedge aclk);
    endtask
    // all-zero wake character
    // thirteen low bit times, then mark idle
    task automatic send_wake(input int bit_cyc);
        hold(1'h0, 13 * bit_cyc);
        hold(1'h1, 2 * bit_cyc);
    endtask
    // lsb first, one start bit, stop plus idle after
    task automatic send_byte(input int bit_cyc, input logic [7:0] d);
        hold(1'h0, bit_cyc);
        for (int i = 0; i < 8; i++)
            hold(d[i], bit_cyc);
        hold(1'h1, 2 * bit_cyc);
    endtask
endmodule
